// ==== scst_pkg.sv ====
// scst_pkg: constants shared by the soft control and status block.
// assumes a 25 MHz reference clock and a 32-bit Avalon-MM register bus.
package scst_pkg;

   // reference clock
   localparam int unsigned CLK_HZ        = 25000000;
   localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;

   // documented limits, in milliseconds
   localparam int unsigned T_OFF_MS      = 100;
   localparam int unsigned T_ON_MS       = 100;
   localparam int unsigned T_INIT_MS     = 300;
   localparam int unsigned T_FAULT_MS    = 100;
   localparam int unsigned T_LOSS_MS     = 100;
   localparam int unsigned T_DATA_MS     = 1000;
   localparam int unsigned T_SERIAL_MS   = 300;

   // longest times round down to whole cycles
   localparam int unsigned INIT_CYC      = T_INIT_MS * CYC_PER_MS;
   localparam int unsigned DATA_CYC      = T_DATA_MS * CYC_PER_MS;
   localparam int unsigned SERIAL_CYC    = T_SERIAL_MS * CYC_PER_MS;

   // register byte offsets
   localparam logic [3:0] OFS_CTRL       = 4'h0;
   localparam logic [3:0] OFS_STATUS     = 4'h4;
   localparam logic [3:0] OFS_EVENT      = 4'h8;
   localparam logic [3:0] OFS_MASK       = 4'hc;

   // control fields
   localparam int unsigned CTRL_TX_OFF   = 0;
   localparam int unsigned CTRL_RATE_SEL = 1;
   localparam int unsigned CTRL_LINK_SYN = 2;
   localparam int unsigned CTRL_W        = 3;
   localparam logic [2:0]  CTRL_RST      = 3'h0;

   // status fields
   localparam int unsigned ST_TX_FAULT   = 0;
   localparam int unsigned ST_LIGHT_ABS  = 1;
   localparam int unsigned ST_DATA_RDY   = 2;
   localparam int unsigned ST_LASER_ON   = 3;
   localparam int unsigned ST_PENDING    = 4;
   localparam int unsigned ST_W          = 5;

   // event and mask fields
   localparam int unsigned EV_FAULT      = 0;
   localparam int unsigned EV_LOST       = 1;
   localparam int unsigned EV_FOUND      = 2;
   localparam int unsigned EV_DREADY     = 3;
   localparam int unsigned EV_W          = 4;
   localparam logic [3:0]  EV_RST        = 4'h0;

endpackage

// ==== scst_sync.sv ====
// scst_sync: two-flop synchroniser, one per bit.
// assumes inputs are asynchronous to ref_clk_i.
`timescale 1ns/10ps
module scst_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         ref_clk_i,   // reference clock
   input  wire logic         reset_n_i,   // sync reset, active low
   input  wire logic [W-1:0] async_i,     // raw inputs
   output logic      [W-1:0] sync_o       // synchronised levels
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_r;
   logic [W-1:0] sync_nxt;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_comb begin
            meta_nxt[g] = async_i[g];
            sync_nxt[g] = meta_r[g];
         end
      end
   endgenerate

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_o = sync_r;

endmodule

// ==== scst_top.sv ====
// scst_top: soft control and status logic of an optical transceiver.
// assumes the Avalon-MM master and the fault, light and serial-bus pins
// are outside this clock domain only where noted; pins are synchronised.
//
// Behaviour
// - soft shut-off darkens laser within 100 ms
// - clearing shut-off relights laser within 100 ms
// - laser stable 300 ms after power or fault clear
// - transmitter fault status set within 100 ms
// - light-absent status set within 100 ms
// - light-absent status cleared within 100 ms
// - bandwidth select bit stored, changes nothing
// - analog data ready flag within 1000 ms
// - management bus accepts transfers within 300 ms
// - soft write latency starts at clock fall after stop
`timescale 1ns/10ps
module scst_top
   import scst_pkg::*;
#(
   parameter int unsigned INIT_CYCLES   = INIT_CYC,
   parameter int unsigned DATA_CYCLES   = DATA_CYC,
   parameter int unsigned SERIAL_CYCLES = SERIAL_CYC
) (
   input  wire logic        ref_clk_i,          // 25 MHz clock
   input  wire logic        reset_n_i,          // sync reset, active low
   input  wire logic [3:0]  avs_address_i,      // byte address
   input  wire logic        avs_read_i,         // read request
   input  wire logic        avs_write_i,        // write request
   input  wire logic [31:0] avs_writedata_i,    // write data
   input  wire logic [3:0]  avs_byteenable_i,   // byte lanes
   output logic      [31:0] avs_readdata_o,     // read data
   output logic             avs_waitrequest_o,  // stall, active high
   input  wire logic        tx_fault_i,         // laser driver fault pin
   input  wire logic        light_absent_i,     // receiver loss of light
   input  wire logic        mgmt_scl_i,         // serial bus clock
   input  wire logic        mgmt_sda_i,         // serial bus data
   output logic             laser_enable_o,     // laser drive on
   output logic             irq_o               // level interrupt
);

   // synchronised pins
   logic [3:0] pins_s;
   logic       fault_s;
   logic       absent_s;
   logic       scl_s;
   logic       sda_s;

   scst_sync #(
      .W (4)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   ({mgmt_sda_i, mgmt_scl_i, light_absent_i, tx_fault_i}),
      .sync_o    (pins_s)
   );

   assign fault_s  = pins_s[0];
   assign absent_s = pins_s[1];
   assign scl_s    = pins_s[2];
   assign sda_s    = pins_s[3];

   // serial bus watcher: stop condition, then next falling clock
   logic scl_q_r,  scl_q_nxt;
   logic sda_q_r,  sda_q_nxt;
   logic stop_r,   stop_nxt;
   logic apply_r,  apply_nxt;

   always_comb begin
      scl_q_nxt = scl_s;
      sda_q_nxt = sda_s;
      stop_nxt  = stop_r;
      apply_nxt = 1'b0;
      if (scl_s && scl_q_r && sda_s && !sda_q_r) begin
         stop_nxt = 1'b1;
      end else if (stop_r && scl_q_r && !scl_s) begin
         stop_nxt  = 1'b0;
         apply_nxt = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         // match the synchroniser's reset level: no false edge after reset
         scl_q_r <= 1'b0;
         sda_q_r <= 1'b0;
         stop_r  <= 1'b0;
         apply_r <= 1'b0;
      end else begin
         scl_q_r <= scl_q_nxt;
         sda_q_r <= sda_q_nxt;
         stop_r  <= stop_nxt;
         apply_r <= apply_nxt;
      end
   end

   // power-on timing
   logic [31:0] por_cnt_r, por_cnt_nxt;
   logic        bus_rdy_r, bus_rdy_nxt;
   logic        data_rdy_r, data_rdy_nxt;

   // saturates at DATA_CYCLES, so SERIAL_CYCLES must not exceed it
   always_comb begin
      por_cnt_nxt  = por_cnt_r;
      if (por_cnt_r < DATA_CYCLES) begin
         por_cnt_nxt = por_cnt_r + 32'h1;
      end
      bus_rdy_nxt  = bus_rdy_r  | (por_cnt_r >= SERIAL_CYCLES);
      data_rdy_nxt = data_rdy_r | (por_cnt_r >= DATA_CYCLES);
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         por_cnt_r  <= 32'h0;
         bus_rdy_r  <= 1'b0;
         data_rdy_r <= 1'b0;
      end else begin
         por_cnt_r  <= por_cnt_nxt;
         bus_rdy_r  <= bus_rdy_nxt;
         data_rdy_r <= data_rdy_nxt;
      end
   end

   // register bus: one-cycle answer, waitrequest low for one cycle
   logic [CTRL_W-1:0] ctrl_r,    ctrl_nxt;
   logic              pend_r,    pend_nxt;
   logic              pend_v_r,  pend_v_nxt;
   logic [EV_W-1:0]   event_r,   event_nxt;
   logic [EV_W-1:0]   mask_r,    mask_nxt;
   logic [31:0]       rdata_r,   rdata_nxt;
   logic              wait_r,    wait_nxt;
   logic [ST_W-1:0]   status;
   logic              wr_take;
   logic              wr_lane0;
   logic [EV_W-1:0]   ev_set;

   // state driven by the laser logic below
   logic              fault_r;
   logic              absent_r;
   logic              laser_r;

   assign wr_take  = avs_write_i && !wait_r;
   assign wr_lane0 = wr_take && avs_byteenable_i[0];

   always_comb begin
      status               = '0;
      status[ST_TX_FAULT]  = fault_r;
      status[ST_LIGHT_ABS] = absent_r;
      status[ST_DATA_RDY]  = data_rdy_r;
      status[ST_LASER_ON]  = laser_r;
      status[ST_PENDING]   = pend_r;
   end

   always_comb begin
      wait_nxt  = 1'b1;
      rdata_nxt = rdata_r;
      // refused until the management side is up
      if ((avs_read_i || avs_write_i) && wait_r && bus_rdy_r) begin
         wait_nxt  = 1'b0;
         rdata_nxt = 32'h0;
         if (avs_read_i) begin
            case (avs_address_i)
               OFS_CTRL:   rdata_nxt = {29'h0, ctrl_r};
               OFS_STATUS: rdata_nxt = {27'h0, status};
               OFS_EVENT:  rdata_nxt = {28'h0, event_r};
               OFS_MASK:   rdata_nxt = {28'h0, mask_r};
               default:    rdata_nxt = 32'h0;
            endcase
         end
      end
   end

   always_comb begin
      ctrl_nxt   = ctrl_r;
      pend_nxt   = pend_r;
      pend_v_nxt = pend_v_r;
      mask_nxt   = mask_r;
      if (wr_lane0 && avs_address_i == OFS_CTRL) begin
         // bandwidth select is stored for read-back only
         ctrl_nxt[CTRL_RATE_SEL] = avs_writedata_i[CTRL_RATE_SEL];
         ctrl_nxt[CTRL_LINK_SYN] = avs_writedata_i[CTRL_LINK_SYN];
         if (avs_writedata_i[CTRL_LINK_SYN]) begin
            pend_nxt   = 1'b1;
            pend_v_nxt = avs_writedata_i[CTRL_TX_OFF];
         end else begin
            pend_nxt = 1'b0;
            ctrl_nxt[CTRL_TX_OFF] = avs_writedata_i[CTRL_TX_OFF];
         end
      end else if (pend_r && apply_r) begin
         // timed from the clock fall after the serial stop
         pend_nxt = 1'b0;
         ctrl_nxt[CTRL_TX_OFF] = pend_v_r;
      end
      if (wr_lane0 && avs_address_i == OFS_MASK) begin
         mask_nxt = avs_writedata_i[EV_W-1:0];
      end
   end

   always_comb begin
      event_nxt = event_r;
      if (wr_lane0 && avs_address_i == OFS_EVENT) begin
         event_nxt = event_r & ~avs_writedata_i[EV_W-1:0];
      end
      // a new event wins over a clear in the same cycle
      event_nxt = event_nxt | ev_set;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         ctrl_r   <= CTRL_RST;
         pend_r   <= 1'b0;
         pend_v_r <= 1'b0;
         event_r  <= EV_RST;
         mask_r   <= EV_RST;
         rdata_r  <= 32'h0;
         wait_r   <= 1'b1;
      end else begin
         ctrl_r   <= ctrl_nxt;
         pend_r   <= pend_nxt;
         pend_v_r <= pend_v_nxt;
         event_r  <= event_nxt;
         mask_r   <= mask_nxt;
         rdata_r  <= rdata_nxt;
         wait_r   <= wait_nxt;
      end
   end

   // laser and receiver status
   logic [31:0] init_cnt_r, init_cnt_nxt;
   logic        fault_nxt;
   logic        absent_nxt;
   logic        laser_nxt;
   logic        irq_r, irq_nxt;
   logic        init_done;

   assign init_done = (init_cnt_r >= INIT_CYCLES);

   always_comb begin
      fault_nxt = fault_r;
      if (fault_s) begin
         fault_nxt = 1'b1;
      end else if (ctrl_r[CTRL_TX_OFF]) begin
         // a fault is only reset by setting the shut-off bit
         fault_nxt = 1'b0;
      end
      absent_nxt = absent_s;
      // restart the settle time while a fault holds the laser off
      init_cnt_nxt = init_cnt_r;
      if (fault_r) begin
         init_cnt_nxt = 32'h0;
      end else if (!init_done) begin
         init_cnt_nxt = init_cnt_r + 32'h1;
      end
      // one cycle from the shut-off bit to the laser drive
      laser_nxt = init_done && !fault_r
                  && !ctrl_r[CTRL_TX_OFF];
      irq_nxt   = |(event_r & mask_r);
   end

   always_comb begin
      ev_set            = '0;
      ev_set[EV_FAULT]  = fault_nxt && !fault_r;
      ev_set[EV_LOST]   = absent_nxt && !absent_r;
      ev_set[EV_FOUND]  = !absent_nxt && absent_r;
      ev_set[EV_DREADY] = data_rdy_nxt && !data_rdy_r;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         fault_r    <= 1'b0;
         absent_r   <= 1'b0;
         init_cnt_r <= 32'h0;
         laser_r    <= 1'b0;
         irq_r      <= 1'b0;
      end else begin
         fault_r    <= fault_nxt;
         absent_r   <= absent_nxt;
         init_cnt_r <= init_cnt_nxt;
         laser_r    <= laser_nxt;
         irq_r      <= irq_nxt;
      end
   end

   assign avs_readdata_o    = rdata_r;
   assign avs_waitrequest_o = wait_r;
   assign laser_enable_o    = laser_r;
   assign irq_o             = irq_r;

endmodule

// ==== scst_host_model.sv ====
// scst_host_model: management bus host that ends a frame with a stop, then one more clock fall and rise.
// assumes pulled-up lines, so both idle high between frames.
`timescale 1ns/10ps
module scst_host_model #(
   parameter int HALF = 160     // half period, scaled like the counts
) (
   input  wire logic go_i,      // start one frame
   output logic      scl_o,     // serial clock
   output logic      sda_o      // serial data
);
   // clock stands high outside frames: it never runs free
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      forever begin
         @(posedge go_i);
         scl_o = 1'b0;
         #HALF sda_o = 1'b0;
         #HALF scl_o = 1'b1;
         #HALF sda_o = 1'b1;    // stop: data rises, clock high
         #HALF scl_o = 1'b0;    // soft write latency starts here
         #HALF scl_o = 1'b1;
      end
   end
endmodule

// ==== scst_top_sva.sv ====
// scst_top_sva: port-level checks of the soft control block.
// assumes a bind to scst_top with the same counts.
`timescale 1ns/10ps
module scst_chk
   import scst_pkg::*;
#(
   parameter int unsigned INIT_CYCLES   = 40,
   parameter int unsigned SERIAL_CYCLES = 20
) (
   input wire logic        ref_clk_i,         // clock
   input wire logic        reset_n_i,         // reset
   input wire logic [3:0]  avs_address_i,     // address
   input wire logic        avs_read_i,        // read
   input wire logic        avs_write_i,       // write
   input wire logic [31:0] avs_writedata_i,   // wdata
   input wire logic [3:0]  avs_byteenable_i,  // lanes
   input wire logic        avs_waitrequest_o, // stall
   input wire logic        tx_fault_i,        // fault
   input wire logic        laser_enable_o,    // laser
   input wire logic        irq_o              // irq
);
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic        wr_ctrl;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   // saturating, so a long run never wraps into the early window
   always_comb cnt_nxt = (&cnt_r) ? cnt_r : cnt_r + 32'h1;
   always_ff @(posedge ref_clk_i) cnt_r <= reset_n_i ? cnt_nxt : 32'h0;
   assign wr_ctrl = avs_write_i && !avs_waitrequest_o
                    && avs_byteenable_i[0] && avs_address_i == OFS_CTRL;
   property p_early;
      cnt_r < SERIAL_CYCLES |-> avs_waitrequest_o;
   endproperty
   a_early: assert property (p_early) else $error("early answer");
   property p_answer;
      (cnt_r > SERIAL_CYCLES + 3 && (avs_read_i || avs_write_i)
       && avs_waitrequest_o) |=> !avs_waitrequest_o;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_one;
      !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_one: assert property (p_one) else $error("long answer");
   property p_dark;
      cnt_r < INIT_CYCLES |-> !laser_enable_o;
   endproperty
   a_dark: assert property (p_dark) else $error("early laser");
   property p_off;
      wr_ctrl && avs_writedata_i[0] && !avs_writedata_i[2]
      |-> ##[1:3] !laser_enable_o;
   endproperty
   a_off: assert property (p_off) else $error("laser stays on");
   property p_inert;
      (!tx_fault_i [*4] ##0 (wr_ctrl && avs_writedata_i[2:0] == 3'h2
       && laser_enable_o)) |=> laser_enable_o [*2];
   endproperty
   a_inert: assert property (p_inert) else $error("laser moved");
   property p_fault;
      $rose(tx_fault_i) |-> ##[1:5] !laser_enable_o;
   endproperty
   a_fault: assert property (p_fault) else $error("fault ignored");
   property p_rst;
      disable iff (1'b0)
      !reset_n_i |=> avs_waitrequest_o && !laser_enable_o && !irq_o;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset");
endmodule
bind scst_top scst_chk #(
   .INIT_CYCLES(INIT_CYCLES),
   .SERIAL_CYCLES(SERIAL_CYCLES)
) u_chk (
   .ref_clk_i(ref_clk_i),
   .reset_n_i(reset_n_i),
   .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i),
   .avs_waitrequest_o(avs_waitrequest_o),
   .tx_fault_i(tx_fault_i),
   .laser_enable_o(laser_enable_o),
   .irq_o(irq_o)
);

// ==== testbench.sv ====
// testbench: drives scst_top over Avalon-MM, checks pins and status.
// assumes shortened power-on counts and a host model on the serial pins.
`timescale 1ns/10ps
module testbench;
   import scst_pkg::*;
   typedef struct {
      logic [3:0]  a;
      logic [3:0]  be;
      logic [31:0] d;
      logic [31:0] x;
      logic        l;
   } scst_row_s;
   localparam int unsigned INIT = 40;
   localparam int unsigned DATA = 100;
   localparam int unsigned SER  = 20;
   logic        ref_clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic        rd_en = 1'b0;
   logic        wr_en = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  ben = 4'h0;
   logic [31:0] rdat;
   logic        wait_o;
   logic        fault = 1'b0;
   logic        dark = 1'b0;
   logic        scl;
   logic        sda;
   logic        go = 1'b0;
   logic        laser;
   logic        irq;
   logic [31:0] q;
   int          n;
   int          n_errors = 0;
   int          cmp_count = 0;
   scst_row_s   rows [6] = '{
      '{4'h0, 4'h1, 32'h2, 32'h2, 1'b1},
      '{4'h0, 4'h1, 32'h1, 32'h1, 1'b0},
      '{4'h0, 4'h0, 32'h0, 32'h1, 1'b0},   // lane 0 off: ignored
      '{4'h0, 4'h1, 32'h0, 32'h0, 1'b1},
      '{4'h2, 4'h1, 32'hff, 32'h0, 1'b1},  // unmapped
      '{4'hc, 4'h1, 32'h1f, 32'hf, 1'b1}};
   always #20 ref_clk_i = ~ref_clk_i;
   scst_top #(.INIT_CYCLES(INIT), .DATA_CYCLES(DATA),
              .SERIAL_CYCLES(SER)) DUT (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .avs_address_i(adr),
      .avs_read_i(rd_en),
      .avs_write_i(wr_en),
      .avs_writedata_i(wdat),
      .avs_byteenable_i(ben),
      .avs_readdata_o(rdat),
      .avs_waitrequest_o(wait_o),
      .tx_fault_i(fault),
      .light_absent_i(dark),
      .mgmt_scl_i(scl),
      .mgmt_sda_i(sda),
      .laser_enable_o(laser),
      .irq_o(irq));
   scst_host_model u_host (.go_i(go), .scl_o(scl), .sda_o(sda));
   task automatic fail(input string m);
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
   endtask
   task automatic chk_word(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) fail($sformatf("word %h not %h", g, x));
   endtask
   task automatic chk_flag(input logic g, input logic x);
      cmp_count++;
      if (g !== x) fail($sformatf("flag %b not %b", g, x));
   endtask
   task automatic bus(input logic w, input logic [3:0] a, b,
                      input logic [31:0] d);
      adr <= a;
      ben <= b;
      wdat <= d;
      wr_en <= w;
      rd_en <= !w;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (wait_o !== 1'b0);
      q = rdat;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] x);
      bus(1'b0, a, 4'h1, 32'h0);
      chk_word(q, x);
   endtask
   task automatic wait_laser(input int lim);
      n = 0;
      while (laser !== 1'b1 && n < lim) begin
         @(posedge ref_clk_i);
         n++;
      end
      chk_flag(laser, 1'b1);
   endtask
   task automatic stop_test;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge ref_clk_i);
      fail("watchdog");
      stop_test;
   end
   initial begin
      repeat (4) @(posedge ref_clk_i);
      chk_flag(wait_o, 1'b1);
      chk_flag(laser, 1'b0);
      reset_n_i <= 1'b1;
      @(posedge ref_clk_i);
      bus(1'b0, OFS_STATUS, 4'h1, 32'h0);
      chk_flag(n >= SER - 1, 1'b1);
      chk_word(q, 32'h0);
      wait_laser(INIT + 5);
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].be, rows[i].d);
         rd(rows[i].a, rows[i].x);
         chk_flag(laser, rows[i].l);
      end
      // host trusts analog values only after the ready flag
      repeat (DATA) @(posedge ref_clk_i);
      rd(OFS_STATUS, 32'hc);
      chk_flag(irq, 1'b1);
      bus(1'b1, OFS_MASK, 4'h1, 32'h0);
      rd(OFS_EVENT, 32'h8);
      chk_flag(irq, 1'b0);
      bus(1'b1, OFS_MASK, 4'h1, 32'hf);
      bus(1'b1, OFS_EVENT, 4'h1, 32'hf);
      rd(OFS_EVENT, 32'h0);
      chk_flag(irq, 1'b0);
      dark <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      rd(OFS_STATUS, 32'he);
      chk_flag(irq, 1'b1);
      dark <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      rd(OFS_STATUS, 32'hc);
      rd(OFS_EVENT, 32'h6);
      bus(1'b1, OFS_EVENT, 4'h1, 32'hf);
      fault <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      fault <= 1'b0;
      rd(OFS_STATUS, 32'h5);
      bus(1'b1, OFS_CTRL, 4'h1, 32'h1);
      rd(OFS_STATUS, 32'h4);
      bus(1'b1, OFS_CTRL, 4'h1, 32'h0);
      chk_flag(laser, 1'b0);
      wait_laser(INIT + 5);
      bus(1'b1, OFS_CTRL, 4'h1, 32'h5);
      rd(OFS_STATUS, 32'h1c);
      go <= 1'b1;
      // the frame's first clock fall comes before the stop: still pending
      repeat (8) @(posedge ref_clk_i);
      rd(OFS_STATUS, 32'h1c);
      repeat (22) @(posedge ref_clk_i);
      rd(OFS_STATUS, 32'h4);
      chk_flag(laser, 1'b0);
      // second reset in mid-run: everything restarts
      reset_n_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      @(posedge ref_clk_i);
      chk_flag(wait_o, 1'b1);
      chk_flag(laser, 1'b0);
      rd(OFS_CTRL, 32'h0);
      chk_flag(n >= SER - 1, 1'b1);
      stop_test;
   end
endmodule
